// ---- design/hah_pkg.sv ----
// Package for the host access hazard controller: device register offsets,
// cycle counts for the strobe timing and the wait tables, software map.
// Assumes a 40 MHz host clock; all counts derive from it.
package hah_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_NS = 25;
	localparam int T_CYCLE_NS = 165;
	localparam int T_LONG_NS = 330;
	localparam int T_CSL_NS = 32;
	localparam int T_CSDV_NS = 30;
	localparam int T_CSH_NS = 13;
	localparam int SYNC_STAGES = 2;
	localparam int CYC_165 = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_330 = (T_LONG_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_CSL = (T_CSL_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_DV = (T_CSDV_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
	localparam int CYC_ASSERT = (CYC_DV > CYC_CSL) ? CYC_DV : CYC_CSL;
	localparam int CYC_CSH = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_RELEASE = (CYC_165 - CYC_ASSERT > CYC_CSH) ?
		CYC_165 - CYC_ASSERT : CYC_CSH;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] NEED_0 = 5'h00;
	localparam logic [CNT_W-1:0] NEED_165 = CNT_W'(CYC_165);
	localparam logic [CNT_W-1:0] NEED_330 = CNT_W'(CYC_330);
	localparam logic [CNT_W-1:0] CNT_SAT = 5'h1f;

	// ------------------------------------------------------------------
	// Device register offsets (byte address on the device pins)
	// ------------------------------------------------------------------
	localparam int DEV_AW = 8;
	localparam logic [7:0] DEV_RX_DATA = 8'h00;
	localparam logic [7:0] DEV_TX_DATA = 8'h20;
	localparam logic [7:0] DEV_RX_STATUS = 8'h40;
	localparam logic [7:0] DEV_TX_STATUS = 8'h48;
	localparam logic [7:0] DEV_CHIP_IDENTITY = 8'h50;
	localparam logic [7:0] DEV_ENDIAN_TEST = 8'h64;
	localparam logic [7:0] DEV_RX_DATAPATH_CTRL = 8'h78;
	localparam logic [7:0] DEV_RX_FIFO_LEVEL = 8'h7c;
	localparam logic [7:0] DEV_TX_FIFO_LEVEL = 8'h80;
	localparam logic [7:0] DEV_POWER_MGMT_CTRL = 8'h84;
	localparam logic [7:0] DEV_FREE_RUN = 8'h9c;
	localparam logic [7:0] DEV_RX_DROP = 8'ha0;

	// ------------------------------------------------------------------
	// Software register map (word index) and fields
	// ------------------------------------------------------------------
	localparam logic [3:0] SW_CMD_ADDR = 4'h0;
	localparam logic [3:0] SW_CMD_WDATA = 4'h1;
	localparam logic [3:0] SW_CMD_GO = 4'h2;
	localparam logic [3:0] SW_CTRL = 4'h3;
	localparam logic [3:0] SW_STATUS = 4'h4;
	localparam logic [3:0] SW_RDATA = 4'h5;
	localparam int CMD_FSEL_BIT = 8;
	localparam int GO_WRITE_BIT = 0;
	localparam int CTRL_DUMMY_BIT = 0;
	localparam int CTRL_FFWD_BIT = 1;
	localparam int CTRL_ENF_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h4;

	// Class of the last read that has a read-after-read side effect
	typedef enum logic [1:0] {
		HAH_RC_NONE = 2'h0,
		HAH_RC_RXFIFO = 2'h1,
		HAH_RC_TXSTAT = 2'h2,
		HAH_RC_DROP = 2'h3
	} hah_rdcls_e;

	function automatic hah_rdcls_e hah_rd_class(input logic [7:0] a, input logic fs);
		hah_rd_class = HAH_RC_NONE;
		if (fs || a == DEV_RX_DATA || a == DEV_RX_STATUS)
			hah_rd_class = HAH_RC_RXFIFO;
		else if (a == DEV_TX_STATUS)
			hah_rd_class = HAH_RC_TXSTAT;
		else if (a == DEV_RX_DROP)
			hah_rd_class = HAH_RC_DROP;
	endfunction

	function automatic logic [CNT_W-1:0] hah_need_wr(input logic [7:0] a, input logic fs,
		input logic ffwd_done);
		hah_need_wr = NEED_165;
		if (fs || a == DEV_RX_DATA || a == DEV_RX_STATUS || a == DEV_TX_STATUS ||
			a == DEV_CHIP_IDENTITY || a == DEV_ENDIAN_TEST ||
			a == DEV_RX_FIFO_LEVEL || a == DEV_RX_DROP)
			hah_need_wr = NEED_0;
		else if (a == DEV_POWER_MGMT_CTRL || a == DEV_FREE_RUN)
			hah_need_wr = NEED_330;
		else if (a == DEV_RX_DATAPATH_CTRL && !ffwd_done)
			hah_need_wr = NEED_0;
	endfunction

	function automatic logic [CNT_W-1:0] hah_need_rd(input hah_rdcls_e c, input logic [7:0] a,
		input logic fs);
		hah_need_rd = NEED_0;
		if (!fs && c == HAH_RC_RXFIFO && a == DEV_RX_FIFO_LEVEL)
			hah_need_rd = NEED_165;
		else if (!fs && c == HAH_RC_TXSTAT && a == DEV_TX_FIFO_LEVEL)
			hah_need_rd = NEED_165;
		else if (!fs && c == HAH_RC_DROP && a == DEV_RX_DROP)
			hah_need_rd = NEED_330;
	endfunction

endpackage

// ---- design/hah_wait_track.sv ----
// Elapsed-time tracker: counts clock cycles since the last write ended and
// since the last side-effect read ended, and says whether a target may be read.
// Assumes end pulses arrive on the edge that raises the strobes.
`timescale 1ns/1ps
module hah_wait_track
	import hah_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic wr_end,
	input wire logic rd_end,
	input wire hah_pkg::hah_rdcls_e rd_cls,
	input wire logic [7:0] tgt_addr,
	input wire logic tgt_fsel,
	input wire logic ffwd_done,
	output logic read_ok,
	output logic [hah_pkg::CNT_W-1:0] wr_elapsed,
	output logic [hah_pkg::CNT_W-1:0] rd_elapsed
);
	import hah_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] wr_el;
		logic [CNT_W-1:0] rd_el;
		hah_rdcls_e cls;
	} hah_trk_s;

	hah_trk_s s_q, s_d;
	logic [CNT_W-1:0] need_w, need_r;

	// Saturating counters; reset leaves no wait pending
	always_comb begin
		s_d = s_q;
		if (s_q.wr_el != CNT_SAT)
			s_d.wr_el = s_q.wr_el + 5'h01;
		if (s_q.rd_el != CNT_SAT)
			s_d.rd_el = s_q.rd_el + 5'h01;
		if (wr_end)
			s_d.wr_el = 5'h00;
		// Only reads with side effects restart the read clock, so dummy reads between count
		if (rd_end && rd_cls != HAH_RC_NONE) begin
			s_d.rd_el = 5'h00;
			s_d.cls = rd_cls;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '{wr_el: CNT_SAT, rd_el: CNT_SAT, cls: HAH_RC_NONE};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Strobes assert one edge after the decision, hence the +1
	always_comb begin
		need_w = hah_need_wr(tgt_addr, tgt_fsel, ffwd_done);
		need_r = hah_need_rd(s_q.cls, tgt_addr, tgt_fsel);
		read_ok = (6'(s_q.wr_el) + 6'h01 >= 6'(need_w)) &&
			(6'(s_q.rd_el) + 6'h01 >= 6'(need_r));
	end

	assign wr_elapsed = s_q.wr_el;
	assign rd_elapsed = s_q.rd_el;

endmodule // hah_wait_track

// ---- design/hah_ctrl.sv ----
// Host-side controller for an asynchronous 16-bit SRAM-like host port.
// Software queues one access at a time; reads are held off until the
// read-after-write and read-after-read waits of the target have elapsed.
// Assumes the device data bus is resolved outside from dev_data_oe_n.
//
// Function
// - Host waits after any write before a read; length set by target read.
// - Most control and status registers need 165 ns after any write.
// - Power management and free-running counter need 330 ns; identity, endian none.
// - Write-to-read wait is timed from the end of the write cycle.
// - Dummy endian-test reads may fill the wait, each worth 165 ns.
// - Fewer dummy reads suffice when elapsed time already meets the wait.
// - Between side-effect reads and their dependent reads the host waits.
// - Receive FIFO reads need 165 ns before the receive level register.
// - Transmit status needs 165 ns before level; drop counter rereads 330 ns.
// - Receive datapath control wait applies only after fast-forward completed.
`timescale 1ns/1ps
module hah_ctrl
	import hah_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output logic host_select_n,
	output logic host_read_strobe_n,
	output logic host_write_strobe_n,
	output logic [hah_pkg::DEV_AW-1:0] dev_addr,
	output logic dev_fifo_sel,
	output logic [15:0] dev_data_out,
	output logic dev_data_oe_n,
	input wire logic [15:0] dev_data_in
);
	import hah_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		HAH_IDLE = 4'h1,
		HAH_CHECK = 4'h2,
		HAH_ASSERT = 4'h4,
		HAH_RELEASE = 4'h8
	} hah_state_e;

	typedef struct packed {
		hah_state_e st;
		logic [3:0] cnt;
		logic [7:0] op_addr;
		logic op_fsel;
		logic [15:0] op_wdata;
		logic op_wr;
		logic dummy;
		logic [7:0] c_addr;
		logic c_fsel;
		logic [15:0] c_wdata;
		logic c_dummy;
		logic c_ffwd;
		logic c_enf;
		logic [15:0] rdata;
		logic rd_valid;
		logic [7:0] stalls;
		logic [31:0] sw_rdata;
		logic sel_n;
		logic rd_n;
		logic wr_n;
		logic oe_n;
		logic [7:0] pa;
		logic pfs;
		logic [15:0] pd;
		logic [15:0] din_s1;
		logic [15:0] din_s2;
	} hah_regs_s;

	localparam logic [3:0] ASSERT_LAST = 4'(CYC_ASSERT - 1);
	localparam logic [3:0] RELEASE_LAST = 4'(CYC_RELEASE - 1);

	hah_regs_s r_q, r_d;
	logic read_ok, wr_end, rd_end, go;
	hah_rdcls_e end_cls;
	logic [CNT_W-1:0] wr_el, rd_el;

	hah_wait_track u_track (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.wr_end(wr_end),
		.rd_end(rd_end),
		.rd_cls(end_cls),
		.tgt_addr(r_q.op_addr),
		.tgt_fsel(r_q.op_fsel),
		.ffwd_done(r_q.c_ffwd),
		.read_ok(read_ok),
		.wr_elapsed(wr_el),
		.rd_elapsed(rd_el)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		wr_end = 1'b0;
		rd_end = 1'b0;
		end_cls = HAH_RC_NONE;
		go = sw_wr && sw_addr == SW_CMD_GO;
		// Pin data first crosses two flip-flops
		r_d.din_s1 = dev_data_in;
		r_d.din_s2 = r_q.din_s1;

		// Software writes; a go while busy is dropped
		if (sw_wr) begin
			case (sw_addr)
				SW_CMD_ADDR: begin
					r_d.c_addr = sw_wdata[7:0];
					r_d.c_fsel = sw_wdata[CMD_FSEL_BIT];
				end
				SW_CMD_WDATA: r_d.c_wdata = sw_wdata[15:0];
				SW_CTRL: begin
					r_d.c_dummy = sw_wdata[CTRL_DUMMY_BIT];
					r_d.c_ffwd = sw_wdata[CTRL_FFWD_BIT];
					r_d.c_enf = sw_wdata[CTRL_ENF_BIT];
				end
				default: ;
			endcase
		end

		r_d.sw_rdata = 32'h0;
		if (sw_rd) begin
			case (sw_addr)
				SW_CMD_ADDR: r_d.sw_rdata = {23'h0, r_q.c_fsel, r_q.c_addr};
				SW_CMD_WDATA: r_d.sw_rdata = {16'h0, r_q.c_wdata};
				SW_CTRL: r_d.sw_rdata = {29'h0, r_q.c_enf, r_q.c_ffwd, r_q.c_dummy};
				SW_STATUS: r_d.sw_rdata = {16'h0, r_q.stalls, 5'h0, r_q.rd_valid,
					r_q.st == HAH_CHECK, r_q.st != HAH_IDLE};
				SW_RDATA: begin
					r_d.sw_rdata = {16'h0, r_q.rdata};
					r_d.rd_valid = 1'b0;
				end
				default: r_d.sw_rdata = 32'h0;
			endcase
		end

		case (r_q.st)
			HAH_IDLE: begin
				if (go) begin
					r_d.op_addr = r_q.c_addr;
					r_d.op_fsel = r_q.c_fsel;
					r_d.op_wdata = r_q.c_wdata;
					r_d.op_wr = sw_wdata[GO_WRITE_BIT];
					r_d.st = HAH_CHECK;
				end
			end
			HAH_CHECK: begin
				r_d.cnt = 4'h0;
				if (r_q.op_wr || read_ok || !r_q.c_enf) begin
					r_d.st = HAH_ASSERT;
					r_d.sel_n = 1'b0;
					r_d.pa = r_q.op_addr;
					r_d.pfs = r_q.op_fsel;
					if (r_q.op_wr) begin
						r_d.wr_n = 1'b0;
						r_d.pd = r_q.op_wdata;
						r_d.oe_n = 1'b0;
					end else begin
						r_d.rd_n = 1'b0;
					end
				end else begin
					if (r_q.stalls != 8'hff)
						r_d.stalls = r_q.stalls + 8'h01;
					// Endian-test reads have no wait and no side effect
					if (r_q.c_dummy) begin
						r_d.st = HAH_ASSERT;
						r_d.dummy = 1'b1;
						r_d.sel_n = 1'b0;
						r_d.rd_n = 1'b0;
						r_d.pa = DEV_ENDIAN_TEST;
						r_d.pfs = 1'b0;
					end
				end
			end
			HAH_ASSERT: begin
				r_d.cnt = r_q.cnt + 4'h1;
				if (r_q.cnt == ASSERT_LAST) begin
					r_d.cnt = 4'h0;
					r_d.sel_n = 1'b1;
					r_d.rd_n = 1'b1;
					r_d.wr_n = 1'b1;
					r_d.st = HAH_RELEASE;
					if (r_q.op_wr && !r_q.dummy) begin
						wr_end = 1'b1;
					end else begin
						rd_end = 1'b1;
						end_cls = r_q.dummy ? HAH_RC_NONE : hah_rd_class(r_q.op_addr, r_q.op_fsel);
					end
					// Data has been settled through the synchroniser
					if (!r_q.op_wr && !r_q.dummy) begin
						r_d.rdata = r_q.din_s2;
						r_d.rd_valid = 1'b1;
					end
				end
			end
			HAH_RELEASE: begin
				r_d.cnt = r_q.cnt + 4'h1;
				if (r_q.cnt == RELEASE_LAST) begin
					r_d.cnt = 4'h0;
					r_d.oe_n = 1'b1;
					r_d.dummy = 1'b0;
					r_d.st = r_q.dummy ? HAH_CHECK : HAH_IDLE;
				end
			end
			default: r_d.st = HAH_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_q <= '0;
			r_q.st <= HAH_IDLE;
			r_q.c_enf <= CTRL_RESET[CTRL_ENF_BIT];
			r_q.sel_n <= 1'b1;
			r_q.rd_n <= 1'b1;
			r_q.wr_n <= 1'b1;
			r_q.oe_n <= 1'b1;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	assign sw_rdata = r_q.sw_rdata;
	assign host_select_n = r_q.sel_n;
	assign host_read_strobe_n = r_q.rd_n;
	assign host_write_strobe_n = r_q.wr_n;
	assign dev_addr = r_q.pa;
	assign dev_fifo_sel = r_q.pfs;
	assign dev_data_out = r_q.pd;
	assign dev_data_oe_n = r_q.oe_n;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	localparam int A_REL = CYC_RELEASE;
	logic rd_start, pair_rx, pair_tx, pair_drop;
	assign rd_start = ce && r_q.st == HAH_CHECK && r_d.st == HAH_ASSERT && !r_d.rd_n &&
		!r_d.dummy && r_q.c_enf;
	assign pair_rx = r_q.op_addr == DEV_RX_FIFO_LEVEL && !r_q.op_fsel;
	assign pair_tx = r_q.op_addr == DEV_TX_FIFO_LEVEL && !r_q.op_fsel;
	assign pair_drop = r_q.op_addr == DEV_RX_DROP && !r_q.op_fsel;

	sequence s_strobes_up;
		host_select_n && host_read_strobe_n && host_write_strobe_n;
	endsequence
	sequence s_read_low;
		!host_select_n && !host_read_strobe_n;
	endsequence

	strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(!host_read_strobe_n && !host_write_strobe_n))
		else $error("read and write strobes low together");
	wr_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_start && hah_need_wr(r_q.op_addr, r_q.op_fsel, r_q.c_ffwd) == NEED_165
		|-> wr_el >= 5'h06)
		else $error("read issued under 165 ns after write");
	long_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_start && !r_q.op_fsel &&
		(r_q.op_addr == DEV_POWER_MGMT_CTRL || r_q.op_addr == DEV_FREE_RUN)
		|-> wr_el >= 5'h0d)
		else $error("read issued under 330 ns after write");
	pair_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_start && (pair_rx || pair_tx) && u_track.s_q.cls != HAH_RC_NONE &&
		u_track.s_q.cls != HAH_RC_DROP && hah_need_rd(u_track.s_q.cls, r_q.op_addr,
		r_q.op_fsel) != NEED_0 |-> rd_el >= 5'h06)
		else $error("level read too soon after FIFO read");
	drop_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_start && pair_drop && u_track.s_q.cls == HAH_RC_DROP |-> rd_el >= 5'h0d)
		else $error("drop counter reread too soon");
	ffwd_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && r_q.st == HAH_CHECK && !r_q.op_wr && !r_q.c_ffwd && r_q.c_enf &&
		r_q.op_addr == DEV_RX_DATAPATH_CTRL && !r_q.op_fsel && rd_el == CNT_SAT
		|=> !host_read_strobe_n)
		else $error("datapath control read held before fast-forward done");
	capture_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && r_q.st == HAH_ASSERT && r_q.cnt == ASSERT_LAST && !r_q.op_wr && !r_q.dummy
		|-> s_read_low ##1 (r_q.rd_valid && r_q.rdata == $past(r_q.din_s2)))
		else $error("read data not captured at end of strobe");
	release_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && r_q.st == HAH_ASSERT && r_q.cnt == ASSERT_LAST
		|=> s_strobes_up ##0 (r_q.st == HAH_RELEASE) ##0 (wr_el == 5'h00 || !r_q.op_wr ||
		r_q.dummy))
		else $error("strobes not released or write clock not restarted");
	stall_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && r_q.st == HAH_CHECK && !r_q.op_wr && r_q.c_enf && !read_ok && !r_q.c_dummy
		|=> s_strobes_up and (r_q.st == HAH_CHECK))
		else $error("read not stalled while wait pending");
	rel_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && r_q.st == HAH_RELEASE && r_q.cnt == 4'(A_REL - 1) |=> r_q.st != HAH_RELEASE)
		else $error("release phase length wrong");

endmodule // hah_ctrl

// ---- test/hah_dev_model.sv ----
// Behavioural model of the SRAM-like device behind the host port.
// Assumes strobes come from one host clock domain; all spacing is judged in ns.
`timescale 1ns/1ps
module hah_dev_model
	import hah_pkg::*;
(
	input wire logic host_select_n,
	input wire logic host_read_strobe_n,
	input wire logic host_write_strobe_n,
	input wire logic [7:0] dev_addr,
	input wire logic dev_fifo_sel,
	input wire logic [15:0] dev_data_out,
	input wire logic ffwd_done,
	output logic [15:0] dev_data_in,
	output int viol_cnt,
	output int rd_cnt,
	output int dummy_cnt
);
	import hah_pkg::*;

	// ------------------------------------------------------------------
	// Cycle decode and read data
	// ------------------------------------------------------------------
	realtime t_wr, t_start, t_rx, t_tx, t_drop, need, tn;
	logic [7:0] tx_lvl;
	logic [15:0] val;
	logic rd_act;
	logic wr_act;
	assign rd_act = !host_select_n && !host_read_strobe_n;
	assign wr_act = !host_select_n && !host_write_strobe_n;
	always_comb val = (dev_addr == DEV_TX_FIFO_LEVEL) ? {8'h00, tx_lvl} : {8'hc3, dev_addr};
	// No pull on the bus: a released bus shows the inverse so stale data never passes
	assign dev_data_in = rd_act ? val : ~val;

	initial begin
		viol_cnt = 0;
		rd_cnt = 0;
		dummy_cnt = 0;
		tx_lvl = 8'h00;
		t_wr = -1.0e6;
		t_start = -1.0e6;
		t_rx = -1.0e6;
		t_tx = -1.0e6;
		t_drop = -1.0e6;
	end

	// ------------------------------------------------------------------
	// Spacing checks on the host's cycles
	// ------------------------------------------------------------------
	always @(posedge rd_act or posedge wr_act) begin
		if ($realtime - t_start < T_CYCLE_NS)
			viol_cnt++;
		t_start = $realtime;
	end

	// Address and strobes move in one time step; look at the address a little later
	always @(posedge rd_act) begin
		tn = $realtime;
		#1;
		rd_cnt++;
		need = 0;
		if (!dev_fifo_sel) begin
			case (dev_addr)
				DEV_POWER_MGMT_CTRL, DEV_FREE_RUN: need = T_LONG_NS;
				DEV_CHIP_IDENTITY, DEV_ENDIAN_TEST, DEV_RX_FIFO_LEVEL, DEV_RX_DROP: need = 0;
				DEV_RX_DATA, DEV_RX_STATUS, DEV_TX_STATUS: need = 0;
				DEV_RX_DATAPATH_CTRL: need = ffwd_done ? T_CYCLE_NS : 0;
				default: need = T_CYCLE_NS;
			endcase
			if (dev_addr == DEV_RX_FIFO_LEVEL && tn - t_rx < T_CYCLE_NS)
				viol_cnt++;
			if (dev_addr == DEV_TX_FIFO_LEVEL && tn - t_tx < T_CYCLE_NS)
				viol_cnt++;
			if (dev_addr == DEV_RX_DROP && tn - t_drop < T_LONG_NS)
				viol_cnt++;
			if (dev_addr == DEV_ENDIAN_TEST)
				dummy_cnt++;
		end
		if (tn - t_wr < need)
			viol_cnt++;
	end

	always @(negedge rd_act) begin
		if (dev_fifo_sel || dev_addr == DEV_RX_DATA || dev_addr == DEV_RX_STATUS)
			t_rx = $realtime;
		else if (dev_addr == DEV_TX_STATUS)
			t_tx = $realtime;
		else if (dev_addr == DEV_RX_DROP)
			t_drop = $realtime;
	end

	// Level moves late but inside the bound, 5 ns before the 165 ns limit
	always @(negedge wr_act) begin
		t_wr = $realtime;
		if (dev_addr == DEV_TX_DATA)
			tx_lvl <= #(T_CYCLE_NS - 5) tx_lvl + 8'h01;
	end
endmodule // hah_dev_model

// ---- test/hah_ctrl_test.sv ----
// Self-checking bench for the host access hazard controller and device model.
// Assumes a 40 MHz clock and the software map of the controller package.
`timescale 1ns/1ps
module hah_ctrl_test;
	import hah_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] sw_addr = 4'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic ffwd = 1'b0;
	logic [31:0] sw_rdata;
	logic sel_n, rd_n, wr_n, fsel, oe_n;
	logic [7:0] addr;
	logic [15:0] dout, din;
	int viol_cnt, rd_cnt, dummy_cnt;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [15:0] wr_seen = 16'h0;

	// Last word the controller drove during a write strobe
	always @(posedge clk)
		if (!sel_n && !wr_n && !oe_n)
			wr_seen <= dout;

	always #12.5 clk = ~clk;

	hah_ctrl i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.host_select_n(sel_n), .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
		.dev_addr(addr), .dev_fifo_sel(fsel), .dev_data_out(dout), .dev_data_oe_n(oe_n),
		.dev_data_in(din));
	hah_dev_model i_dev (.host_select_n(sel_n), .host_read_strobe_n(rd_n),
		.host_write_strobe_n(wr_n), .dev_addr(addr), .dev_fifo_sel(fsel),
		.dev_data_out(dout), .ffwd_done(ffwd), .dev_data_in(din), .viol_cnt(viol_cnt),
		.rd_cnt(rd_cnt), .dummy_cnt(dummy_cnt));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask

	task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask

	task automatic wait_idle();
		logic [31:0] s;
		for (int i = 0; i < 100; i++) begin
			sw_read(SW_STATUS, s);
			if (s[0] === 1'b0)
				return;
		end
		check("idle reached", 32'h0, 32'h1);
	endtask

	function automatic logic [15:0] exp_val(input logic [7:0] a);
		return (a == DEV_TX_FIFO_LEVEL) ? 16'h0001 : {8'hc3, a};
	endfunction

	// One access, then a read fired at every edge so it lands right after idle.
	// Mode 0 checks the stall, mode 1 dummy reads, mode 2 no enforcement.
	task automatic pair(input logic w1, input logic [7:0] a1, input logic f1,
		input logic [7:0] a2, input logic wt, input int mode);
		logic [31:0] s0, s1, d;
		int v0, r0, d0;
		sw_read(SW_STATUS, s0);
		v0 = viol_cnt;
		r0 = rd_cnt;
		d0 = dummy_cnt;
		sw_write(SW_CMD_ADDR, {23'h0, f1, a1});
		sw_write(SW_CMD_WDATA, {16'h0, 8'h5a, a1});
		sw_write(SW_CMD_GO, {31'h0, w1});
		repeat (2) @(posedge clk);
		sw_write(SW_CMD_ADDR, {24'h0, a2});
		@(posedge clk);
		sw_addr <= SW_CMD_GO;
		sw_wdata <= 32'h0;
		sw_wr <= 1'b1;
		repeat (8) @(posedge clk);
		sw_wr <= 1'b0;
		wait_idle();
		sw_read(SW_STATUS, s1);
		sw_read(SW_RDATA, d);
		check("read data", d, {16'h0, exp_val(a2)});
		if (w1)
			check("write data", {16'h0, wr_seen}, {16'h0, 8'h5a, a1});
		check("bad timing", viol_cnt - v0, (mode == 2) ? 1 : 0);
		if (mode == 0)
			check("stall seen", {31'h0, s1[15:8] != s0[15:8]}, {31'h0, wt});
		if (mode == 0)
			check("pin reads", rd_cnt - r0, w1 ? 1 : 2);
		if (mode == 1)
			check("dummy reads", {31'h0, dummy_cnt > d0}, 32'h1);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		check("idle pins", {28'h0, sel_n, rd_n, wr_n, oe_n}, 32'hf);
		sw_read(SW_CTRL, d);
		check("ctrl reset", d, 32'h4);
		sw_read(SW_STATUS, d);
		check("status reset", d, 32'h0);
		sw_read(SW_RDATA, d);
		check("rdata reset", d, 32'h0);
		sw_read(4'hf, d);
		check("unmapped", d, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_table();
		logic cw [15] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0};
		logic cf [15] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0};
		logic ct [15] = '{1, 0, 0, 0, 0, 1, 1, 1, 0, 1, 1, 1, 1, 1, 0};
		logic [7:0] ca [15] = '{DEV_TX_DATA, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10,
			8'h10, 8'h10, DEV_RX_DATA, DEV_RX_STATUS, 8'h00, DEV_TX_STATUS, DEV_RX_DROP,
			DEV_TX_STATUS};
		logic [7:0] cb [15] = '{DEV_TX_FIFO_LEVEL, DEV_CHIP_IDENTITY, DEV_ENDIAN_TEST,
			DEV_RX_FIFO_LEVEL, DEV_RX_DROP, 8'h74, DEV_POWER_MGMT_CTRL, DEV_FREE_RUN,
			DEV_RX_DATAPATH_CTRL, DEV_RX_FIFO_LEVEL, DEV_RX_FIFO_LEVEL, DEV_RX_FIFO_LEVEL,
			DEV_TX_FIFO_LEVEL, DEV_RX_DROP, DEV_CHIP_IDENTITY};
		for (int i = 0; i < 15; i++)
			pair(cw[i], ca[i], cf[i], cb[i], ct[i], 0);
		$display("test wait table done");
	endtask

	task automatic t_ffwd();
		sw_write(SW_CTRL, 32'h6);
		ffwd <= 1'b1;
		pair(1'b1, 8'h10, 1'b0, DEV_RX_DATAPATH_CTRL, 1'b1, 0);
		sw_write(SW_CTRL, 32'h4);
		ffwd <= 1'b0;
		$display("test fast forward done");
	endtask

	task automatic t_dummy();
		logic [31:0] d;
		sw_write(SW_CTRL, 32'h5);
		sw_read(SW_CTRL, d);
		check("ctrl readback", d, 32'h5);
		pair(1'b1, 8'h10, 1'b0, DEV_POWER_MGMT_CTRL, 1'b1, 1);
		pair(1'b0, DEV_RX_DROP, 1'b0, DEV_RX_DROP, 1'b1, 1);
		sw_write(SW_CTRL, 32'h4);
		$display("test dummy reads done");
	endtask

	task automatic t_loose();
		sw_write(SW_CTRL, 32'h0);
		pair(1'b1, 8'h10, 1'b0, DEV_POWER_MGMT_CTRL, 1'b1, 2);
		sw_write(SW_CTRL, 32'h4);
		$display("test enforcement off done");
	endtask

	// ------------------------------------------------------------------
	// Main sequence and hang guard
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_table();
		t_ffwd();
		t_dummy();
		t_loose();
		give_verdict();
	end
endmodule // hah_ctrl_test
